/* power_ok_pkg.sv */
// constants and types shared by the power-good logic
// -----------------------------------------------------------------------------
// What this block does
// - polarity bit 0 drives output high when valid, 1 drives it low
// - drive-type bit 0 gives push-pull, 1 gives open-drain output
// - regulator window bit 0 checks undervoltage only, 1 checks both
// - converter window bit 0 checks undervoltage only, 1 checks both
// - each rail counts toward live status only while its enable bit is 1; a latched fault counts until cleared
// - thermal gating bit 1 forces inactive during thermal warning
// - fault gating bit 0 shows live status, 1 shows latched faults
// - operating-mode bit 0 is gated mode, 1 is continuous mode
// - latch rail fault on drop, clear by writing 1 once rail valid
// - latch drop event on active-to-inactive change, write 1 clears
// -----------------------------------------------------------------------------
package power_ok_pkg;

	// register offsets
	localparam logic [7:0] CONFIG_A_OFFSET = 8'h15;
	localparam logic [7:0] CONFIG_B_OFFSET = 8'h16;
	localparam logic [7:0] RAIL_FAULT_OFFSET = 8'h17;
	localparam logic [7:0] EVENT_OFFSET = 8'h19;

	// values after reset
	localparam logic [7:0] CONFIG_A_RESET = 8'h73;
	localparam logic [7:0] CONFIG_B_RESET = 8'h04;
	localparam logic [3:0] RAIL_FAULT_RESET = 4'h0;

	// field positions in config a
	localparam int POLARITY_BIT = 7;
	localparam int DRIVE_TYPE_BIT = 6;
	localparam int REG_WINDOW_BIT = 5;
	localparam int CONV_WINDOW_BIT = 4;
	localparam int SOURCE_EN_LSB = 0;

	// field positions in config b
	localparam int THERMAL_GATE_BIT = 2;
	localparam int FAULT_GATE_BIT = 1;
	localparam int MODE_BIT = 0;

	// drop event position in the event register
	localparam int DROP_EVENT_BIT = 7;

	// rail index: 0 converter0, 1 converter1, 2 regulator0, 3 regulator1
	localparam int RAIL_COUNT = 4;
	localparam int FIRST_REGULATOR = 2;

	// comparator results of all rails
	typedef struct packed {
		logic [3:0] under_ok;
		logic [3:0] over_ok;
	} rail_status_t;

	// register access from the serial interface engine
	typedef struct packed {
		logic [7:0] addr;
		logic write;
		logic [7:0] wdata;
	} reg_access_t;

endpackage : power_ok_pkg

/* power_ok_signal_logic.sv */
// power-good generation, fault latches and drop event
`timescale 1ns/1ps
module power_ok_signal_logic (
	input wire logic MCLK,
	input wire logic RESETN,
	input wire power_ok_pkg::reg_access_t REG_ACCESS,
	output logic [7:0] REG_RDATA,
	input wire power_ok_pkg::rail_status_t RAIL_STATUS,
	input wire logic THERMAL_WARNING,
	input wire logic DEVICE_ACTIVE,
	output logic POWER_OK_OUTPUT_O,
	output logic POWER_OK_OUTPUT_OE
);

	// -------------------------------------------------------------------------
	// input synchronisers
	// -------------------------------------------------------------------------
	power_ok_pkg::rail_status_t rail_meta;
	power_ok_pkg::rail_status_t rail_sync;
	logic thermal_meta;
	logic thermal_sync;
	logic active_meta;
	logic active_sync;

	// comparator outputs are analog-side and asynchronous to MCLK
	always_ff @(posedge MCLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			rail_meta <= '1; // rails count as ok until first sample
			rail_sync <= '1; // avoids false fault latches after reset
			thermal_meta <= 1'b0;
			thermal_sync <= 1'b0;
			active_meta <= 1'b0;
			active_sync <= 1'b0;
		end
		else
		begin
			rail_meta <= RAIL_STATUS;
			rail_sync <= rail_meta;
			thermal_meta <= THERMAL_WARNING;
			thermal_sync <= thermal_meta;
			active_meta <= DEVICE_ACTIVE;
			active_sync <= active_meta;
		end
	end

	// -------------------------------------------------------------------------
	// control registers
	// -------------------------------------------------------------------------
	logic [7:0] power_ok_config_a;
	logic [7:0] power_ok_config_b;
	logic wr_a;
	logic wr_b;
	logic wr_fault;
	logic wr_event;

	// single-cycle write decode
	always_comb
	begin
		wr_a = 1'b0;
		wr_b = 1'b0;
		wr_fault = 1'b0;
		wr_event = 1'b0;
		if (REG_ACCESS.addr == power_ok_pkg::CONFIG_A_OFFSET)
			wr_a = REG_ACCESS.write;
		else if (REG_ACCESS.addr == power_ok_pkg::CONFIG_B_OFFSET)
			wr_b = REG_ACCESS.write;
		else if (REG_ACCESS.addr == power_ok_pkg::RAIL_FAULT_OFFSET)
			wr_fault = REG_ACCESS.write;
		else if (REG_ACCESS.addr == power_ok_pkg::EVENT_OFFSET)
			wr_event = REG_ACCESS.write;
	end

	// all eight bits are kept, reserved ones included, as they are read/write
	always_ff @(posedge MCLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			power_ok_config_a <= power_ok_pkg::CONFIG_A_RESET;
			power_ok_config_b <= power_ok_pkg::CONFIG_B_RESET;
		end
		else
		begin
			if (wr_a)
				power_ok_config_a <= REG_ACCESS.wdata;
			if (wr_b)
				power_ok_config_b <= REG_ACCESS.wdata;
		end
	end

	// -------------------------------------------------------------------------
	// per-rail validity
	// -------------------------------------------------------------------------
	logic [3:0] rail_valid;
	logic [3:0] rail_dropping;
	logic [3:0] source_enable;

	assign source_enable = power_ok_config_a[power_ok_pkg::SOURCE_EN_LSB +: 4];

	// the over-voltage check is only added when the rail's window bit is set
	genvar g;
	generate
		for (g = 0; g < power_ok_pkg::RAIL_COUNT; g++)
		begin : rail_check
			logic window;
			assign window = (g >= power_ok_pkg::FIRST_REGULATOR) ?
				power_ok_config_a[power_ok_pkg::REG_WINDOW_BIT] :
				power_ok_config_a[power_ok_pkg::CONV_WINDOW_BIT];
			assign rail_valid[g] = rail_sync.under_ok[g] &
				(rail_sync.over_ok[g] | ~window);
			assign rail_dropping[g] = source_enable[g] & ~rail_valid[g];
		end
	endgenerate

	// -------------------------------------------------------------------------
	// latched rail faults
	// -------------------------------------------------------------------------
	logic [3:0] latched_rail_faults;
	logic [3:0] fault_clear;

	// a clear is honoured only for rails that are valid again
	assign fault_clear = wr_fault ? (REG_ACCESS.wdata[3:0] & rail_valid) : 4'h0;

	// a new drop in the clearing cycle wins over the clear
	always_ff @(posedge MCLK or negedge RESETN)
	begin
		if (!RESETN)
			latched_rail_faults <= power_ok_pkg::RAIL_FAULT_RESET;
		else
			latched_rail_faults <= (latched_rail_faults & ~fault_clear) |
				rail_dropping;
	end

	// -------------------------------------------------------------------------
	// power-good decision
	// -------------------------------------------------------------------------
	logic live_good;
	logic source_good;
	logic next_good;
	logic good;

	// disabled rails count as valid so they drop out of the AND
	assign live_good = &(rail_valid | ~source_enable);

	// in gated mode the signal is held inactive outside active operation
	always_comb
	begin
		if (power_ok_config_b[power_ok_pkg::FAULT_GATE_BIT])
			source_good = ~|latched_rail_faults;
		else
			source_good = live_good;
		next_good = source_good;
		if (power_ok_config_b[power_ok_pkg::THERMAL_GATE_BIT] && thermal_sync)
			next_good = 1'b0;
		if (!power_ok_config_b[power_ok_pkg::MODE_BIT] && !active_sync)
			next_good = 1'b0;
	end

	// registered so the pin never glitches on comparator skew
	always_ff @(posedge MCLK or negedge RESETN)
	begin
		if (!RESETN)
			good <= 1'b0;
		else
			good <= next_good;
	end

	// -------------------------------------------------------------------------
	// pin driver
	// -------------------------------------------------------------------------
	logic level;

	assign level = good ^ power_ok_config_a[power_ok_pkg::POLARITY_BIT];

	// open-drain only ever pulls low; push-pull drives both levels
	always_ff @(posedge MCLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			POWER_OK_OUTPUT_O <= 1'b0;
			POWER_OK_OUTPUT_OE <= 1'b0;
		end
		else if (power_ok_config_a[power_ok_pkg::DRIVE_TYPE_BIT])
		begin
			POWER_OK_OUTPUT_O <= 1'b0;
			POWER_OK_OUTPUT_OE <= ~level;
		end
		else
		begin
			POWER_OK_OUTPUT_O <= level;
			POWER_OK_OUTPUT_OE <= 1'b1;
		end
	end

	// -------------------------------------------------------------------------
	// drop event
	// -------------------------------------------------------------------------
	logic power_ok_drop_event;
	logic drop;

	assign drop = good & ~next_good;

	// set wins over a write-one clear in the same cycle
	always_ff @(posedge MCLK or negedge RESETN)
	begin
		if (!RESETN)
			power_ok_drop_event <= 1'b0;
		else if (drop)
			power_ok_drop_event <= 1'b1;
		else if (wr_event && REG_ACCESS.wdata[power_ok_pkg::DROP_EVENT_BIT])
			power_ok_drop_event <= 1'b0;
	end

	// -------------------------------------------------------------------------
	// read data
	// -------------------------------------------------------------------------
	// read data lags the address by one clock; unmapped addresses read zero
	always_ff @(posedge MCLK or negedge RESETN)
	begin
		if (!RESETN)
			REG_RDATA <= 8'h00;
		else if (REG_ACCESS.addr == power_ok_pkg::CONFIG_A_OFFSET)
			REG_RDATA <= power_ok_config_a;
		else if (REG_ACCESS.addr == power_ok_pkg::CONFIG_B_OFFSET)
			REG_RDATA <= power_ok_config_b;
		else if (REG_ACCESS.addr == power_ok_pkg::RAIL_FAULT_OFFSET)
			REG_RDATA <= {4'h0, latched_rail_faults};
		else if (REG_ACCESS.addr == power_ok_pkg::EVENT_OFFSET)
			REG_RDATA <= {power_ok_drop_event, 7'h00};
		else
			REG_RDATA <= 8'h00;
	end

endmodule : power_ok_signal_logic

/* power_ok_monitor.sv */
// checker watching the power-good block's ports
`timescale 1ns/1ps
module power_ok_monitor (
	input wire logic MCLK,
	input wire logic RESETN,
	input wire power_ok_pkg::reg_access_t REG_ACCESS,
	input wire logic [7:0] REG_RDATA,
	input wire logic THERMAL_WARNING,
	input wire logic DEVICE_ACTIVE,
	input wire logic POWER_OK_OUTPUT_O,
	input wire logic POWER_OK_OUTPUT_OE
);
	logic [7:0] cfg_a;
	logic [2:0] cfg_b;
	logic [2:0] age;
	logic lvl;
	logic cw;
	// ---------------------------------------------------------------
	// shadow configuration
	// ---------------------------------------------------------------
	// pin as a pulled-up line sees it
	assign lvl = POWER_OK_OUTPUT_OE ? POWER_OK_OUTPUT_O : 1'b1;
	assign cw = REG_ACCESS.write && (REG_ACCESS.addr == 8'h15 ||
		REG_ACCESS.addr == 8'h16);
	// age saturates so pin checks wait for the sync pipeline
	always_ff @(posedge MCLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			cfg_a <= 8'h73;
			cfg_b <= 3'h4;
			age <= 3'h0;
		end
		else
		begin
			if (cw && REG_ACCESS.addr == 8'h15)
				cfg_a <= REG_ACCESS.wdata;
			if (cw && REG_ACCESS.addr == 8'h16)
				cfg_b <= REG_ACCESS.wdata[2:0];
			age <= cw ? 3'h0 : (age == 3'h7 ? 3'h7 : age + 3'h1);
		end
	end
	// ---------------------------------------------------------------
	// properties
	// ---------------------------------------------------------------
	AST_OPEN_DRAIN: assert property (
		@(posedge MCLK) disable iff (!RESETN)
		age > 3'h2 && cfg_a[6] |-> !POWER_OK_OUTPUT_O)
		else $error("open-drain pin drove high");
	AST_PUSH_PULL: assert property (
		@(posedge MCLK) disable iff (!RESETN)
		age > 3'h2 && !cfg_a[6] |-> POWER_OK_OUTPUT_OE)
		else $error("push-pull pin released");
	AST_POLARITY: assert property (
		@(posedge MCLK) disable iff (!RESETN)
		age == 3'h7 && cfg_a[3:0] == 4'h0 && cfg_b == 3'h1
		|-> lvl == !cfg_a[7])
		else $error("valid level wrong for polarity");
	AST_THERMAL: assert property (
		@(posedge MCLK) disable iff (!RESETN)
		(age == 3'h7 && cfg_b[2] && THERMAL_WARNING) [*6]
		|-> lvl == cfg_a[7])
		else $error("pin active during thermal warning");
	AST_GATED: assert property (
		@(posedge MCLK) disable iff (!RESETN)
		(age == 3'h7 && !cfg_b[0] && !DEVICE_ACTIVE) [*6]
		|-> lvl == cfg_a[7])
		else $error("gated pin active while inactive device");
	AST_READBACK: assert property (
		@(posedge MCLK) disable iff (!RESETN)
		REG_ACCESS.write && REG_ACCESS.addr == 8'h15 ##1
		!REG_ACCESS.write && REG_ACCESS.addr == 8'h15
		|=> REG_RDATA == $past(REG_ACCESS.wdata, 2))
		else $error("config a readback differs");
	AST_FAULT_TOP: assert property (
		@(posedge MCLK) disable iff (!RESETN)
		$past(REG_ACCESS.addr) == 8'h17 |-> REG_RDATA[7:4] == 4'h0)
		else $error("fault upper bits not zero");
	AST_EVENT_LOW: assert property (
		@(posedge MCLK) disable iff (!RESETN)
		$past(REG_ACCESS.addr) == 8'h19 |-> REG_RDATA[6:0] == 7'h0)
		else $error("event low bits not zero");
endmodule : power_ok_monitor

/* power_ok_host_model.sv */
// reader on the far side of the power-good pin
`timescale 1ns/1ps
module power_ok_host_model (
	input wire logic POWER_OK_OUTPUT_O,
	input wire logic POWER_OK_OUTPUT_OE,
	output logic PIN_LEVEL
);
	// board pull-up holds the line high whenever the device lets go
	assign PIN_LEVEL = POWER_OK_OUTPUT_OE ? POWER_OK_OUTPUT_O : 1'b1;
endmodule : power_ok_host_model

/* tb_top.sv */
// self-checking testbench for the power-good block
`timescale 1ns/1ps
module tb_top;
	logic mclk = 1'b0;
	logic resetn = 1'b0;
	power_ok_pkg::reg_access_t acc = '0;
	power_ok_pkg::rail_status_t rail = 8'hff;
	logic therm = 1'b0;
	logic act = 1'b1;
	logic [7:0] rdata;
	logic o;
	logic oe;
	logic pin;
	int errors = 0;
	int samples_checked = 0;
	// 25 MHz
	always #20 mclk = ~mclk;
	power_ok_signal_logic dut (.MCLK(mclk), .RESETN(resetn),
		.REG_ACCESS(acc), .REG_RDATA(rdata), .RAIL_STATUS(rail),
		.THERMAL_WARNING(therm), .DEVICE_ACTIVE(act),
		.POWER_OK_OUTPUT_O(o), .POWER_OK_OUTPUT_OE(oe));
	power_ok_host_model host (.POWER_OK_OUTPUT_O(o),
		.POWER_OK_OUTPUT_OE(oe), .PIN_LEVEL(pin));
	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	task automatic chk(input string n, input logic [7:0] e, g);
		samples_checked++;
		if (g !== e)
		begin
			errors++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, d);
		@(negedge mclk);
		acc = '{addr: a, write: 1'b1, wdata: d};
		@(negedge mclk);
		acc.write = 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, e, input string n);
		@(negedge mclk);
		acc.addr = a;
		@(negedge mclk);
		chk(n, e, rdata);
	endtask : rd
	// long enough for sync, pin register and the checker's quiet time
	task automatic pin_is(input logic e, input string n);
		repeat (12) @(negedge mclk);
		chk(n, {7'h0, e}, {7'h0, pin});
	endtask : pin_is
	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic t_reset;
		rd(8'h15, 8'h73, "cfg_a");
		rd(8'h16, 8'h04, "cfg_b");
		rd(8'h17, 8'h00, "faults");
		rd(8'h20, 8'h00, "unmapped");
		$display("t_reset end");
	endtask : t_reset
	task automatic t_pin;
		wr(8'h16, 8'h01);
		wr(8'h15, 8'h00);
		pin_is(1'b1, "pp pol0");
		wr(8'h15, 8'h80);
		pin_is(1'b0, "pp pol1");
		wr(8'h15, 8'h40);
		pin_is(1'b1, "od pol0");
		wr(8'h15, 8'hc0);
		pin_is(1'b0, "od pol1");
		$display("t_pin end");
	endtask : t_pin
	task automatic t_window;
		wr(8'h15, 8'h01);
		rail.over_ok = 4'h0;
		pin_is(1'b1, "conv under");
		wr(8'h15, 8'h11);
		pin_is(1'b0, "conv both");
		wr(8'h15, 8'h04);
		pin_is(1'b1, "reg under");
		wr(8'h15, 8'h24);
		pin_is(1'b0, "reg both");
		rail.over_ok = 4'hf;
		rd(8'h17, 8'h05, "fault set");
		rd(8'h19, 8'h80, "drop set");
		wr(8'h19, 8'h80);
		wr(8'h17, 8'h0f);
		rd(8'h19, 8'h00, "drop clr");
		rd(8'h17, 8'h00, "fault clr");
		$display("t_window end");
	endtask : t_window
	task automatic t_fault;
		wr(8'h15, 8'h01);
		wr(8'h16, 8'h03);
		rail.under_ok = 4'he;
		pin_is(1'b0, "rail lost");
		wr(8'h15, 8'h00);
		wr(8'h17, 8'h01);
		rd(8'h17, 8'h01, "clr refused");
		rail.under_ok = 4'hf;
		wr(8'h15, 8'h01);
		pin_is(1'b0, "fault held");
		wr(8'h17, 8'h01);
		pin_is(1'b1, "fault gone");
		$display("t_fault end");
	endtask : t_fault
	task automatic t_gate;
		wr(8'h15, 8'h00);
		wr(8'h16, 8'h05);
		therm = 1'b1;
		pin_is(1'b0, "thermal");
		wr(8'h16, 8'h00);
		therm = 1'b0;
		act = 1'b0;
		pin_is(1'b0, "gated");
		wr(8'h16, 8'h01);
		therm = 1'b1;
		pin_is(1'b1, "continuous");
		$display("t_gate end");
	endtask : t_gate
	task automatic final_report;
		$display("checks %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : final_report
	initial
	begin
		repeat (2) @(negedge mclk);
		resetn = 1'b1;
		t_reset();
		t_pin();
		t_window();
		t_fault();
		t_gate();
		final_report();
	end
	// a hung run ends here as a mismatch
	initial
	begin
		#1ms;
		errors++;
		final_report();
	end
endmodule : tb_top
bind power_ok_signal_logic power_ok_monitor mon (.MCLK(MCLK),
	.RESETN(RESETN), .REG_ACCESS(REG_ACCESS), .REG_RDATA(REG_RDATA),
	.THERMAL_WARNING(THERMAL_WARNING), .DEVICE_ACTIVE(DEVICE_ACTIVE),
	.POWER_OK_OUTPUT_O(POWER_OK_OUTPUT_O),
	.POWER_OK_OUTPUT_OE(POWER_OK_OUTPUT_OE));
